// ===== logic/dtc_timer.sv
// Dual 16-bit timer/counter with control, mode and APB register access
`timescale 1ns/1ns
`include "dtc_defs.svh"

module dtc_timer
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // External pins
  input  wire logic [1:0]  count_pin_i,
  input  wire logic [1:0]  external_irq_pin_i,
  // Vectoring acknowledges, bit0 timer0, bit1 timer1
  input  wire logic [1:0]  tmr_vec_ack_i,
  input  wire logic [1:0]  irq_vec_ack_i,
  // Interrupt
  output logic             irq_o
);

  logic [7:0]  timer_control_ff;
  logic [7:0]  timer_mode_ff;
  logic [15:0] cnt0_ff;
  logic [15:0] cnt1_ff;
  logic [4:0]  pre0_ff;
  logic [4:0]  pre1_ff;
  logic [1:0]  cpin_d_ff;
  logic [1:0]  ipin_d_ff;
  logic [3:0]  istat_ff;
  logic [3:0]  imask_ff;
  logic [31:0] prdata_ff;

  dtc_tmode_t  tm0;
  dtc_tmode_t  tm1;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [1:0]  tick;
  logic [1:0]  allow;
  logic        split;
  logic        inc_lo0;
  logic        inc_hi0;
  logic        inc1;
  logic        ovf0;
  logic        ovf1;
  logic [15:0] nxt_cnt0;
  logic [15:0] nxt_cnt1;
  logic [4:0]  nxt_pre0;
  logic [4:0]  nxt_pre1;

  assign tm0 = dtc_tmode_t'(timer_mode_ff[3:0]);
  assign tm1 = dtc_tmode_t'(timer_mode_ff[7:4]);
  assign split = (tm0.mode == `DTC_M_SPLIT);

  // APB decode; zero wait states
  assign wr_en  = psel_i & penable_i & pwrite_i;
  assign rd_en  = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  always_comb begin
    case (paddr_i)
      `DTC_OFF_CTRL, `DTC_OFF_MODE, `DTC_OFF_T0, `DTC_OFF_T1,
      `DTC_OFF_ACK, `DTC_OFF_ISTAT, `DTC_OFF_IMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Last pin levels for falling-edge detect; idle-high reset avoids a false edge
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpin_d_ff <= `DTC_RST_PINS;
      ipin_d_ff <= `DTC_RST_PINS;
    end else begin
      cpin_d_ff <= count_pin_i;
      ipin_d_ff <= external_irq_pin_i;
    end
  end
  // Counter input counts falling edges of the count pin when ext_src is set, else every core clock
  assign tick[0] = tm0.ext_src ? (cpin_d_ff[0] & ~count_pin_i[0]) : 1'b1;
  assign tick[1] = tm1.ext_src ? (cpin_d_ff[1] & ~count_pin_i[1]) : 1'b1;
  // Gate: run alone, or run and pin high
  assign allow[0] = timer_control_ff[`DTC_B_T0_RUN]
                    & (~tm0.gate | external_irq_pin_i[0]);
  assign allow[1] = timer_control_ff[`DTC_B_T1_RUN]
                    & (~tm1.gate | external_irq_pin_i[1]);

  // In split mode the high byte runs off the core clock under timer1 run
  assign inc_lo0 = allow[0] & tick[0];
  assign inc_hi0 = split & timer_control_ff[`DTC_B_T1_RUN];
  assign inc1    = allow[1] & tick[1] & (tm1.mode != `DTC_M_SPLIT);

  // Timer 0 next count and overflow
  always_comb begin
    nxt_cnt0 = cnt0_ff;
    nxt_pre0 = pre0_ff;
    ovf0     = 1'b0;
    ovf1     = 1'b0;
    case (tm0.mode)
      `DTC_M_13BIT: begin
        if (inc_lo0) begin
          nxt_pre0 = pre0_ff + 5'h01;
          if (pre0_ff == `DTC_PRE_MAX) begin
            nxt_cnt0[15:8] = cnt0_ff[15:8] + 8'h01;
            ovf0 = (cnt0_ff[15:8] == 8'hff);
          end
        end
      end
      `DTC_M_16BIT: begin
        if (inc_lo0) begin
          nxt_cnt0 = cnt0_ff + 16'h0001;
          ovf0 = (cnt0_ff == 16'hffff);
        end
      end
      `DTC_M_RELOAD: begin
        if (inc_lo0) begin
          ovf0 = (cnt0_ff[7:0] == 8'hff);
          nxt_cnt0[7:0] = ovf0 ? cnt0_ff[15:8] : cnt0_ff[7:0] + 8'h01;
        end
      end
      default: begin
        if (inc_lo0) begin
          nxt_cnt0[7:0] = cnt0_ff[7:0] + 8'h01;
          ovf0 = (cnt0_ff[7:0] == 8'hff);
        end
        if (inc_hi0) begin
          nxt_cnt0[15:8] = cnt0_ff[15:8] + 8'h01;
          ovf1 = (cnt0_ff[15:8] == 8'hff);
        end
      end
    endcase
  end

  // Timer 1 next count; its overflow flag is lent out in split mode
  always_comb begin
    nxt_cnt1 = cnt1_ff;
    nxt_pre1 = pre1_ff;
    case (tm1.mode)
      `DTC_M_13BIT: begin
        if (inc1) begin
          nxt_pre1 = pre1_ff + 5'h01;
          if (pre1_ff == `DTC_PRE_MAX)
            nxt_cnt1[15:8] = cnt1_ff[15:8] + 8'h01;
        end
      end
      `DTC_M_16BIT: begin
        if (inc1)
          nxt_cnt1 = cnt1_ff + 16'h0001;
      end
      `DTC_M_RELOAD: begin
        if (inc1)
          nxt_cnt1[7:0] = (cnt1_ff[7:0] == 8'hff) ? cnt1_ff[15:8] : cnt1_ff[7:0] + 8'h01;
      end
      default: nxt_cnt1 = cnt1_ff;
    endcase
  end

  // Timer 1 overflow event, from its own counter; in split mode ovf1 sets the flag as well
  logic t1_ovf;
  always_comb begin
    case (tm1.mode)
      `DTC_M_13BIT:  t1_ovf = inc1 & (pre1_ff == `DTC_PRE_MAX) & (cnt1_ff[15:8] == 8'hff);
      `DTC_M_16BIT:  t1_ovf = inc1 & (cnt1_ff == 16'hffff);
      `DTC_M_RELOAD: t1_ovf = inc1 & (cnt1_ff[7:0] == 8'hff);
      default:       t1_ovf = 1'b0;
    endcase
  end

  // Counters, writable through APB; a write wins over counting
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt0_ff <= `DTC_RST_CNT;
      cnt1_ff <= `DTC_RST_CNT;
      pre0_ff <= 5'h00;
      pre1_ff <= 5'h00;
    end else begin
      cnt0_ff <= (wr_en && paddr_i == `DTC_OFF_T0) ? pwdata_i[15:0] : nxt_cnt0;
      cnt1_ff <= (wr_en && paddr_i == `DTC_OFF_T1) ? pwdata_i[15:0] : nxt_cnt1;
      pre0_ff <= nxt_pre0;
      pre1_ff <= nxt_pre1;
    end
  end

  // External interrupt detect: level when sense 0, falling edge when 1
  logic [1:0] irq_hit;
  assign irq_hit[0] = timer_control_ff[`DTC_B_X0_SNS] ? (ipin_d_ff[0] & ~external_irq_pin_i[0])
                                                   : ~external_irq_pin_i[0];
  assign irq_hit[1] = timer_control_ff[`DTC_B_X1_SNS] ? (ipin_d_ff[1] & ~external_irq_pin_i[1])
                                                   : ~external_irq_pin_i[1];

  // Control register: hardware sets beat clears in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_control_ff <= `DTC_RST_BYTE;
    end else begin
      // Software write first, then hardware clears, then sets
      if (wr_en && paddr_i == `DTC_OFF_CTRL)
        timer_control_ff <= pwdata_i[7:0];
      else begin
        if (tmr_vec_ack_i[0]) timer_control_ff[`DTC_B_T0_OVF] <= 1'b0;
        if (tmr_vec_ack_i[1]) timer_control_ff[`DTC_B_T1_OVF] <= 1'b0;
        // Level mode flag follows the pin, edge mode is cleared by vectoring
        if (irq_vec_ack_i[0] && timer_control_ff[`DTC_B_X0_SNS])
          timer_control_ff[`DTC_B_X0_FLG] <= 1'b0;
        if (!timer_control_ff[`DTC_B_X0_SNS]) timer_control_ff[`DTC_B_X0_FLG] <= irq_hit[0];
        if (irq_vec_ack_i[1] && timer_control_ff[`DTC_B_X1_SNS])
          timer_control_ff[`DTC_B_X1_FLG] <= 1'b0;
        if (!timer_control_ff[`DTC_B_X1_SNS]) timer_control_ff[`DTC_B_X1_FLG] <= irq_hit[1];
      end
      if (ovf0) timer_control_ff[`DTC_B_T0_OVF] <= 1'b1;
      if (ovf1 || t1_ovf) timer_control_ff[`DTC_B_T1_OVF] <= 1'b1;
      if (irq_hit[0]) timer_control_ff[`DTC_B_X0_FLG] <= 1'b1;
      if (irq_hit[1]) timer_control_ff[`DTC_B_X1_FLG] <= 1'b1;
    end
  end

  // Bit access to control is done by whole-word write; the spare offset is inert
  // Mode register only takes whole-byte writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_mode_ff <= `DTC_RST_BYTE;
    end else if (wr_en && paddr_i == `DTC_OFF_MODE) begin
      timer_mode_ff <= pwdata_i[7:0];
    end
  end

  // Sticky status: overflow 0, overflow 1, ext irq 0, ext irq 1; read clears, set wins
  logic [3:0] ev;
  assign ev = {irq_hit[1], irq_hit[0], ovf1 | t1_ovf, ovf0};
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      istat_ff <= `DTC_RST_ST;
      imask_ff <= `DTC_RST_ST;
    end else begin
      if (rd_en && paddr_i == `DTC_OFF_ISTAT)
        istat_ff <= ev;
      else
        istat_ff <= istat_ff | ev;
      if (wr_en && paddr_i == `DTC_OFF_IMASK)
        imask_ff <= pwdata_i[3:0];
    end
  end
  assign irq_o = |(istat_ff & imask_ff);

  // Read data registered in the setup cycle so it is valid in access
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      case (paddr_i)
        `DTC_OFF_CTRL:  prdata_ff <= {24'h00_0000, timer_control_ff};
        `DTC_OFF_MODE:  prdata_ff <= {24'h00_0000, timer_mode_ff};
        `DTC_OFF_T0:    prdata_ff <= {16'h0000, cnt0_ff};
        `DTC_OFF_T1:    prdata_ff <= {16'h0000, cnt1_ff};
        `DTC_OFF_ISTAT: prdata_ff <= {28'h000_0000, istat_ff | ev};  // Setup-cycle events kept
        `DTC_OFF_IMASK: prdata_ff <= {28'h000_0000, imask_ff};
        default:        prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata_o = prdata_ff;

  // Assertions
  a_run_halt_t1: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tm1.mode == `DTC_M_SPLIT && !(wr_en && paddr_i == `DTC_OFF_T1))
      |=> cnt1_ff == $past(cnt1_ff)) else $error("timer1 moved in mode 3");
  a_gate_blocks: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tm0.gate && !external_irq_pin_i[0] && tm0.mode == `DTC_M_16BIT
      && !(wr_en && paddr_i == `DTC_OFF_T0)) |=> cnt0_ff == $past(cnt0_ff))
    else $error("gated timer0 counted");
  a_run_counts: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!tm0.gate && !tm0.ext_src && timer_control_ff[`DTC_B_T0_RUN]
      && tm0.mode == `DTC_M_16BIT && !wr_en) |=> cnt0_ff == $past(cnt0_ff) + 16'h0001)
    else $error("timer0 did not count");
  a_tf0_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ovf0 |=> timer_control_ff[`DTC_B_T0_OVF]) else $error("timer0 flag not set");
  a_tf1_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ovf1 || t1_ovf) |=> timer_control_ff[`DTC_B_T1_OVF])
    else $error("timer1 flag not set");
  a_reload_t0: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tm0.mode == `DTC_M_RELOAD && ovf0 && !wr_en) |=> cnt0_ff[7:0] == cnt0_ff[15:8])
    else $error("reload failed");
  a_split_hi: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (split && !timer_control_ff[`DTC_B_T1_RUN] && !wr_en)
      |=> cnt0_ff[15:8] == $past(cnt0_ff[15:8])) else $error("high byte ran");
  a_mode_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_en && paddr_i == `DTC_OFF_MODE) |=> timer_mode_ff == $past(pwdata_i[7:0]))
    else $error("mode write lost");
  a_edge_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (timer_control_ff[`DTC_B_X0_SNS] && irq_hit[0]) |=> timer_control_ff[`DTC_B_X0_FLG])
    else $error("edge not caught");

endmodule : dtc_timer

// ===== include/dtc_defs.svh
// Register offsets, field positions, reset values and mode codes for the dual timer
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// APB byte offsets
`define DTC_OFF_CTRL     12'h000
`define DTC_OFF_MODE     12'h004
`define DTC_OFF_T0       12'h008
`define DTC_OFF_T1       12'h00c
`define DTC_OFF_ACK      12'h010
`define DTC_OFF_ISTAT    12'h014
`define DTC_OFF_IMASK    12'h018
// Control register bit positions
`define DTC_B_T1_OVF     7
`define DTC_B_T1_RUN     6
`define DTC_B_T0_OVF     5
`define DTC_B_T0_RUN     4
`define DTC_B_X1_FLG     3
`define DTC_B_X1_SNS     2
`define DTC_B_X0_FLG     1
`define DTC_B_X0_SNS     0
// Reset values
`define DTC_RST_BYTE     8'h00
`define DTC_RST_CNT      16'h0000
`define DTC_RST_ST       4'h0
`define DTC_RST_PINS     2'h3
// Mode codes
`define DTC_M_13BIT      2'h0
`define DTC_M_16BIT      2'h1
`define DTC_M_RELOAD     2'h2
`define DTC_M_SPLIT      2'h3
// 13-bit mode prescaler wraps at 5 bits
`define DTC_PRE_MAX      5'h1f
`endif

// ===== include/dtc_pkg.sv
// Types shared by the dual timer block
package dtc_pkg;
  // One timer's four mode bits
  typedef struct packed {
    logic       gate;
    logic       ext_src;
    logic [1:0] mode;
  } dtc_tmode_t;
  // Edge/level detector state
  typedef enum logic [1:0] {
    DTC_IDLE = 2'b00,
    DTC_HIGH = 2'b01,
    DTC_LOW  = 2'b11
  } dtc_pin_st_t;
endpackage : dtc_pkg

// ===== sim/dtc_pin_model.sv
// Model of the external count and interrupt/gate pins
`timescale 1ns/1ns
module dtc_pin_model (
  // Clock
  input  wire logic       clk_i,
  // Pins
  output logic      [1:0] count_pin_o,
  output logic      [1:0] irq_pin_o
);
  // Pins rest high, like a port line with a pull-up
  initial begin
    count_pin_o = 2'h3;
    irq_pin_o   = 2'h3;
  end
  // Each level is held for several clocks so the falling-edge detector sees it
  task automatic pulse(input int idx, input int cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      count_pin_o[idx] <= 1'b0;
      repeat (3) @(posedge clk_i);
      count_pin_o[idx] <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulse
  // Level change on an interrupt or gate pin
  task automatic set_irq(input int idx, input logic lvl);
    @(posedge clk_i);
    irq_pin_o[idx] <= lvl;
  endtask : set_irq
endmodule : dtc_pin_model

// ===== sim/dtc_timer_tb.sv
// Self-checking testbench of the dual timer block
`timescale 1ns/1ns
`include "dtc_defs.svh"
module dtc_timer_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] addr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [1:0]  cpin;
  logic [1:0]  ipin;
  logic [1:0]  tack;
  logic [1:0]  iack;
  logic [31:0] q_exp[$];
  logic [31:0] q_err[$];
  string       q_nm[$];
  logic [15:0] v;
  int          n;
  int          error_cnt = 0;
  int          n_compared = 0;

  dtc_timer dtc_timer_i (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat),
    .pready_o(pready), .pslverr_o(pslverr), .count_pin_i(cpin),
    .external_irq_pin_i(ipin), .tmr_vec_ack_i(tack), .irq_vec_ack_i(iack), .irq_o(irq));
  dtc_pin_model pm_i (.clk_i(clk), .count_pin_o(cpin), .irq_pin_o(ipin));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Setup cycle, then access until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  // Expectation is queued before the read goes out
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    q_exp.push_back(e);
    q_nm.push_back(nm);
    q_err.push_back({31'h0, a > 12'h018});
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // One-cycle vectoring pulse, {irq acks, timer acks}
  task automatic vec(input logic [3:0] m);
    @(posedge clk);
    {iack, tack} <= m;
    @(posedge clk);
    {iack, tack} <= 4'h0;
  endtask : vec

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Read data and error flag are taken at the completing edge
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready && q_exp.size() > 0) begin
      chk(q_nm.pop_front(), q_exp.pop_front(), rdat);
      chk("slverr", q_err.pop_front(), {31'h0, pslverr});
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Tests need a few hundred cycles; this is far beyond
  initial begin
    #800000;
    error_cnt++;
    close_out();
  end

  initial begin
    {psel, pen, pwr, addr, wdat, tack, iack} = '0;
    rst = 1'b1;
    void'($urandom(75));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, whole-byte mode register, unmapped place
    rd(`DTC_OFF_CTRL, 32'h0, "ctrl");
    rd(12'h020, 32'h0, "unmapped");
    wr(`DTC_OFF_MODE, 32'hffffff5a);
    rd(`DTC_OFF_MODE, 32'h5a, "mode");
    // External source, gate clear, pin low, random start
    pm_i.set_irq(0, 1'b0);
    v = 16'($urandom) & 16'hfff0;
    n = 1 + $urandom % 8;
    wr(`DTC_OFF_T0, {16'h0, v});
    wr(`DTC_OFF_MODE, 32'h05);
    wr(`DTC_OFF_CTRL, 32'h10);
    pm_i.pulse(0, n);
    wr(`DTC_OFF_CTRL, 32'h00);
    rd(`DTC_OFF_T0, {16'h0, v + 16'(n)}, "t0 ext");
    // Gate set: pin low blocks, pin high lets it count
    wr(`DTC_OFF_T0, 32'h0);
    wr(`DTC_OFF_MODE, 32'h0d);
    wr(`DTC_OFF_CTRL, 32'h10);
    pm_i.pulse(0, 3);
    rd(`DTC_OFF_T0, 32'h0, "t0 gated");
    pm_i.set_irq(0, 1'b1);
    pm_i.pulse(0, 2);
    rd(`DTC_OFF_T0, 32'h2, "t0 open");
    // Timer 1 auto-reload, flag, ack, status and interrupt
    wr(`DTC_OFF_CTRL, 32'h00);
    wr(`DTC_OFF_T1, 32'hfdfe);
    wr(`DTC_OFF_MODE, 32'h60);
    wr(`DTC_OFF_CTRL, 32'h40);
    pm_i.pulse(1, 3);
    rd(`DTC_OFF_T1, 32'hfdfe, "t1 reload");
    rd(`DTC_OFF_CTRL, 32'hc0, "ctrl tf1");
    vec(4'h2);
    rd(`DTC_OFF_CTRL, 32'h40, "ctrl tf1 ack");
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(`DTC_OFF_IMASK, 32'h2);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd(`DTC_OFF_ISTAT, 32'h6, "istat");
    rd(`DTC_OFF_ISTAT, 32'h0, "istat clr");
    #1 chk("irq clr", 32'h0, {31'h0, irq});
    // Timer 1 in mode 3 holds its count
    wr(`DTC_OFF_T1, 32'h10);
    wr(`DTC_OFF_MODE, 32'h70);
    pm_i.pulse(1, 3);
    rd(`DTC_OFF_T1, 32'h10, "t1 halt");
    // Split timer 0: low byte on own bits, high byte on timer 1 bits
    wr(`DTC_OFF_CTRL, 32'h00);
    wr(`DTC_OFF_T0, 32'hf000);
    wr(`DTC_OFF_MODE, 32'h77);
    wr(`DTC_OFF_CTRL, 32'h10);
    pm_i.pulse(0, 4);
    wr(`DTC_OFF_CTRL, 32'h00);
    rd(`DTC_OFF_T0, 32'hf004, "t0 split");
    wr(`DTC_OFF_CTRL, 32'h40);
    repeat (30) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'hc0, "split tf1");
    // 16-bit internal overflow; run bit untouched by hardware
    wr(`DTC_OFF_CTRL, 32'h00);
    wr(`DTC_OFF_T0, 32'hfff0);
    wr(`DTC_OFF_MODE, 32'h01);
    wr(`DTC_OFF_CTRL, 32'h10);
    repeat (30) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'h30, "tf0");
    vec(4'h1);
    rd(`DTC_OFF_CTRL, 32'h10, "tf0 ack");
    // 13-bit mode overflows where 16-bit would not
    wr(`DTC_OFF_CTRL, 32'h00);
    wr(`DTC_OFF_T0, 32'hff1e);
    wr(`DTC_OFF_MODE, 32'h00);
    wr(`DTC_OFF_CTRL, 32'h10);
    repeat (40) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'h30, "tf0 13bit");
    // Timer 0 auto-reload from its high byte, external source
    wr(`DTC_OFF_CTRL, 32'h00);
    wr(`DTC_OFF_T0, 32'h80fe);
    wr(`DTC_OFF_MODE, 32'h06);
    wr(`DTC_OFF_CTRL, 32'h10);
    pm_i.pulse(0, 3);
    rd(`DTC_OFF_T0, 32'h8081, "t0 reload");
    rd(`DTC_OFF_CTRL, 32'h30, "tf0 reload");
    // External interrupt 0 on falling edge, 1 on low level
    wr(`DTC_OFF_CTRL, 32'h01);
    pm_i.set_irq(0, 1'b0);
    pm_i.set_irq(0, 1'b1);
    repeat (4) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'h03, "ie0 edge");
    vec(4'h4);
    rd(`DTC_OFF_CTRL, 32'h01, "ie0 ack");
    wr(`DTC_OFF_CTRL, 32'h00);
    pm_i.set_irq(1, 1'b0);
    repeat (4) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'h08, "ie1 low");
    pm_i.set_irq(1, 1'b1);
    repeat (4) @(posedge clk);
    rd(`DTC_OFF_CTRL, 32'h00, "ie1 high");
    rd(`DTC_OFF_ISTAT, 32'hf, "istat all");
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : dtc_timer_tb
